// *** leis_regs.svh ***
// register map, field positions and codes of the link event action selector
// Functional notes
// - port A link-down action field sits in control bits 5:3.
// - port B link-up action field sits in control bits 8:6.
// - port B link-down action field sits in control bits 11:9.
// - port C link-up action field sits in control bits 14:12.
// - act when status bit sets; INTx actions also send negate on clear.
// - action code 0x0 masks the event, no message sent.
// - action code 0x1 sends an MSI per MSI capability settings.
// - codes 0x2..0x5 send assert then negate on INTA..INTD.
// - MSI only sent while MSI enable is set.
// - INTx messages suppressed while INTx disable is set.
// - port A link-up action field sits in control bits 2:0.
// - port C link-down action field sits in control bits 17:15.
`ifndef LEIS_REGS_SVH
`define LEIS_REGS_SVH

`define LEIS_ADDR_W 12
`define LEIS_DATA_W 32
`define LEIS_CTRL_OFS 12'h210
`define LEIS_IRQ_STAT_OFS 12'h220
`define LEIS_IRQ_MASK_OFS 12'h224

`define LEIS_CTRL_W 18
`define LEIS_CTRL_RST 18'h00000
`define LEIS_FIELD_W 3
`define LEIS_NUM_EVT 6
`define LEIS_IDX_W 3

`define LEIS_PA_UP_LSB 0
`define LEIS_PA_DN_LSB 3
`define LEIS_PB_UP_LSB 6
`define LEIS_PB_DN_LSB 9
`define LEIS_PC_UP_LSB 12
`define LEIS_PC_DN_LSB 15

`define LEIS_CODE_OFF 3'h0
`define LEIS_CODE_MSI 3'h1
`define LEIS_CODE_INTA 3'h2
`define LEIS_CODE_INTD 3'h5

`define LEIS_IRQ_W 4
`define LEIS_IRQ_RST 4'h0
`define LEIS_IRQ_MSI_SENT 0
`define LEIS_IRQ_INTX_SENT 1
`define LEIS_IRQ_SUPPRESS 2
`define LEIS_IRQ_OVERRUN 3

`endif

// *** leis_pkg.sv ***
// types and decode helpers of the link event action selector
`include "leis_regs.svh"

package leis_pkg;

  typedef enum logic [1:0] {
    LEIS_NONE,
    LEIS_MSI,
    LEIS_ASSERT,
    LEIS_NEGATE
  } leis_kind_t;

  // message owed for one edge of a status bit under the given action code
  function automatic leis_kind_t leis_action(
    input logic [`LEIS_FIELD_W-1:0] code,
    input logic rise,
    input logic msiEn,
    input logic intxOff
  );
    leis_kind_t k;
    k = LEIS_NONE;
    if (code == `LEIS_CODE_MSI) begin
      if (rise && msiEn) begin
        k = LEIS_MSI;
      end
    end else if (code >= `LEIS_CODE_INTA && code <= `LEIS_CODE_INTD &&
                 !intxOff) begin
      k = rise ? LEIS_ASSERT : LEIS_NEGATE;
    end
    return k;
  endfunction

  // INTA..INTD as 0..3
  function automatic logic [1:0] leis_pin(
    input logic [`LEIS_FIELD_W-1:0] code
  );
    logic [`LEIS_FIELD_W-1:0] d;
    d = code - `LEIS_CODE_INTA;
    return d[1:0];
  endfunction

endpackage

// *** leis_edge_detect.sv ***
// rise and fall pulses of the event status flags
`timescale 1ns/1ps
`include "leis_regs.svh"

module leis_edge_detect (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // status levels, same clock domain
  input wire logic [`LEIS_NUM_EVT-1:0] level,
  // edge pulses
  output logic [`LEIS_NUM_EVT-1:0] rise,
  output logic [`LEIS_NUM_EVT-1:0] fall
);

  logic [`LEIS_NUM_EVT-1:0] prev_reg;
  logic [`LEIS_NUM_EVT-1:0] prev_next;

  always_comb begin
    prev_next = level;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule

// *** leis_pick.sv ***
// fixed priority pick of the lowest pending event
`timescale 1ns/1ps
`include "leis_regs.svh"

module leis_pick (
  // pending events
  input wire logic [`LEIS_NUM_EVT-1:0] pend,
  // chosen event
  output logic [`LEIS_IDX_W-1:0] grantIdx,
  output logic grantAny
);

  always_comb begin
    grantIdx = '0;
    grantAny = |pend;
    // scan downwards so the lowest index wins
    for (int i = `LEIS_NUM_EVT - 1; i >= 0; i--) begin
      if (pend[i]) begin
        grantIdx = i[`LEIS_IDX_W-1:0];
      end
    end
  end

endmodule

// *** leis_top.sv ***
// link event interrupt action selector with register port and message out
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "leis_regs.svh"

module leis_top (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [`LEIS_ADDR_W-1:0] regAddr,
  input wire logic [`LEIS_DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [`LEIS_DATA_W-1:0] regRdData,
  // event status flags and gating bits
  input wire logic [`LEIS_NUM_EVT-1:0] eventFlags,
  input wire logic msiEnable,
  input wire logic intxDisable,
  // upstream message request
  output logic msgValid,
  input wire logic msgReady,
  output leis_pkg::leis_kind_t msgKind,
  output logic [1:0] msgPin,
  output logic [`LEIS_IDX_W-1:0] msgEvent,
  // block interrupt
  output logic irq
);

  logic [`LEIS_CTRL_W-1:0] ctrl_reg;
  logic [`LEIS_CTRL_W-1:0] ctrl_next;
  logic [`LEIS_IRQ_W-1:0] irqStat_reg;
  logic [`LEIS_IRQ_W-1:0] irqStat_next;
  logic [`LEIS_IRQ_W-1:0] irqMask_reg;
  logic [`LEIS_IRQ_W-1:0] irqMask_next;
  logic [`LEIS_DATA_W-1:0] rdData_reg;
  logic [`LEIS_DATA_W-1:0] rdData_next;

  leis_pkg::leis_kind_t pendKind_reg [`LEIS_NUM_EVT];
  leis_pkg::leis_kind_t pendKind_next [`LEIS_NUM_EVT];
  logic [1:0] pendPin_reg [`LEIS_NUM_EVT];
  logic [1:0] pendPin_next [`LEIS_NUM_EVT];

  logic outValid_reg;
  logic outValid_next;
  leis_pkg::leis_kind_t outKind_reg;
  leis_pkg::leis_kind_t outKind_next;
  logic [1:0] outPin_reg;
  logic [1:0] outPin_next;
  logic [`LEIS_IDX_W-1:0] outEvent_reg;
  logic [`LEIS_IDX_W-1:0] outEvent_next;

  logic [`LEIS_FIELD_W-1:0] actionCode [`LEIS_NUM_EVT];
  leis_pkg::leis_kind_t edgeKind [`LEIS_NUM_EVT];
  logic [`LEIS_NUM_EVT-1:0] rise;
  logic [`LEIS_NUM_EVT-1:0] fall;
  logic [`LEIS_NUM_EVT-1:0] pendAny;
  logic [`LEIS_IDX_W-1:0] grantIdx;
  logic grantAny;
  logic loadOut;
  logic [`LEIS_IRQ_W-1:0] irqEvt;

  leis_edge_detect u_edge (
    .clk(clk),
    .srst(srst),
    .level(eventFlags),
    .rise(rise),
    .fall(fall)
  );

  leis_pick u_pick (
    .pend(pendAny),
    .grantIdx(grantIdx),
    .grantAny(grantAny)
  );

  // action fields, one per event, in index order
  always_comb begin
    actionCode[0] = ctrl_reg[`LEIS_PA_UP_LSB +: `LEIS_FIELD_W];
    actionCode[1] = ctrl_reg[`LEIS_PA_DN_LSB +: `LEIS_FIELD_W];
    actionCode[2] = ctrl_reg[`LEIS_PB_UP_LSB +: `LEIS_FIELD_W];
    actionCode[3] = ctrl_reg[`LEIS_PB_DN_LSB +: `LEIS_FIELD_W];
    actionCode[4] = ctrl_reg[`LEIS_PC_UP_LSB +: `LEIS_FIELD_W];
    actionCode[5] = ctrl_reg[`LEIS_PC_DN_LSB +: `LEIS_FIELD_W];
  end

  // codes 0, reserved codes and gated codes all decode to no message
  always_comb begin
    for (int i = 0; i < `LEIS_NUM_EVT; i++) begin
      edgeKind[i] = leis_pkg::LEIS_NONE;
      if (rise[i] || fall[i]) begin
        edgeKind[i] = leis_pkg::leis_action(actionCode[i], rise[i],
                                            msiEnable, intxDisable);
      end
    end
  end

  // kept apart from the pending logic so the pick feeds no loop back
  always_comb begin
    for (int i = 0; i < `LEIS_NUM_EVT; i++) begin
      pendAny[i] = pendKind_reg[i] != leis_pkg::LEIS_NONE;
    end
  end

  assign loadOut = grantAny && (!outValid_reg || msgReady);

  // pending messages; a fresh edge wins over the take of the old one
  always_comb begin
    irqEvt = '0;
    for (int i = 0; i < `LEIS_NUM_EVT; i++) begin
      pendKind_next[i] = pendKind_reg[i];
      pendPin_next[i] = pendPin_reg[i];
      if (loadOut && grantIdx == i[`LEIS_IDX_W-1:0]) begin
        pendKind_next[i] = leis_pkg::LEIS_NONE;
      end
      if (edgeKind[i] != leis_pkg::LEIS_NONE) begin
        if (pendKind_next[i] != leis_pkg::LEIS_NONE) begin
          irqEvt[`LEIS_IRQ_OVERRUN] = 1'b1;
        end
        pendKind_next[i] = edgeKind[i];
        pendPin_next[i] = leis_pkg::leis_pin(actionCode[i]);
      end else if ((rise[i] || fall[i]) &&
                   actionCode[i] != `LEIS_CODE_OFF &&
                   !(actionCode[i] == `LEIS_CODE_MSI && fall[i])) begin
        irqEvt[`LEIS_IRQ_SUPPRESS] = 1'b1;
      end
    end
    if (loadOut) begin
      if (pendKind_reg[grantIdx] == leis_pkg::LEIS_MSI) begin
        irqEvt[`LEIS_IRQ_MSI_SENT] = 1'b1;
      end else begin
        irqEvt[`LEIS_IRQ_INTX_SENT] = 1'b1;
      end
    end
  end

  // output stage holds a message until the upstream side takes it
  always_comb begin
    outValid_next = outValid_reg;
    outKind_next = outKind_reg;
    outPin_next = outPin_reg;
    outEvent_next = outEvent_reg;
    if (outValid_reg && msgReady) begin
      outValid_next = 1'b0;
    end
    if (loadOut) begin
      outValid_next = 1'b1;
      outKind_next = pendKind_reg[grantIdx];
      outPin_next = pendPin_reg[grantIdx];
      outEvent_next = grantIdx;
    end
  end

  // register port
  always_comb begin
    ctrl_next = ctrl_reg;
    irqMask_next = irqMask_reg;
    // set wins over a write-one clear in the same cycle
    irqStat_next = irqStat_reg;
    if (regWrEn && regAddr == `LEIS_CTRL_OFS) begin
      ctrl_next = regWrData[`LEIS_CTRL_W-1:0];
    end
    if (regWrEn && regAddr == `LEIS_IRQ_MASK_OFS) begin
      irqMask_next = regWrData[`LEIS_IRQ_W-1:0];
    end
    if (regWrEn && regAddr == `LEIS_IRQ_STAT_OFS) begin
      irqStat_next = irqStat_reg & ~regWrData[`LEIS_IRQ_W-1:0];
    end
    irqStat_next = irqStat_next | irqEvt;
    rdData_next = '0;
    if (regRdEn) begin
      case (regAddr)
        `LEIS_CTRL_OFS: begin
          rdData_next = {{(`LEIS_DATA_W-`LEIS_CTRL_W){1'b0}}, ctrl_reg};
        end
        `LEIS_IRQ_STAT_OFS: begin
          rdData_next = {{(`LEIS_DATA_W-`LEIS_IRQ_W){1'b0}}, irqStat_reg};
        end
        `LEIS_IRQ_MASK_OFS: begin
          rdData_next = {{(`LEIS_DATA_W-`LEIS_IRQ_W){1'b0}}, irqMask_reg};
        end
        default: begin
          rdData_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= `LEIS_CTRL_RST;
      irqStat_reg <= `LEIS_IRQ_RST;
      irqMask_reg <= `LEIS_IRQ_RST;
      rdData_reg <= '0;
      outValid_reg <= 1'b0;
      outKind_reg <= leis_pkg::LEIS_NONE;
      outPin_reg <= '0;
      outEvent_reg <= '0;
      for (int i = 0; i < `LEIS_NUM_EVT; i++) begin
        pendKind_reg[i] <= leis_pkg::LEIS_NONE;
        pendPin_reg[i] <= '0;
      end
    end else begin
      ctrl_reg <= ctrl_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      rdData_reg <= rdData_next;
      outValid_reg <= outValid_next;
      outKind_reg <= outKind_next;
      outPin_reg <= outPin_next;
      outEvent_reg <= outEvent_next;
      for (int i = 0; i < `LEIS_NUM_EVT; i++) begin
        pendKind_reg[i] <= pendKind_next[i];
        pendPin_reg[i] <= pendPin_next[i];
      end
    end
  end

  assign regRdData = rdData_reg;
  assign msgValid = outValid_reg;
  assign msgKind = outKind_reg;
  assign msgPin = outPin_reg;
  assign msgEvent = outEvent_reg;
  assign irq = |(irqStat_reg & irqMask_reg);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_field_reset: assert property (
    @(posedge clk) disable iff (1'b0) srst |=> ctrl_reg == `LEIS_CTRL_RST)
    else $error("action fields not masked after reset");

  a_field_write: assert property (
    regWrEn && regAddr == `LEIS_CTRL_OFS
    |=> ctrl_reg == $past(regWrData[`LEIS_CTRL_W-1:0]))
    else $error("control write not held");

  a_out_hold: assert property (
    msgValid && !msgReady |=> msgValid && $stable(msgKind)
                              && $stable(msgEvent))
    else $error("message dropped before taken");

  a_status_sticky: assert property (
    regWrEn && regAddr == `LEIS_IRQ_STAT_OFS && irqEvt != '0
    |=> (irqStat_reg & $past(irqEvt)) == $past(irqEvt))
    else $error("status event lost to a clear");

  for (genvar g = 0; g < `LEIS_NUM_EVT; g++) begin : g_chk
    a_mask_none: assert property (
      rise[g] && actionCode[g] == `LEIS_CODE_OFF
      && pendKind_reg[g] == leis_pkg::LEIS_NONE
      |=> pendKind_reg[g] == leis_pkg::LEIS_NONE)
      else $error("masked event queued a message");

    a_reserved_none: assert property (
      (rise[g] || fall[g]) && actionCode[g] > `LEIS_CODE_INTD
      && pendKind_reg[g] == leis_pkg::LEIS_NONE
      |=> pendKind_reg[g] == leis_pkg::LEIS_NONE)
      else $error("reserved code queued a message");

    a_msi_queued: assert property (
      rise[g] && actionCode[g] == `LEIS_CODE_MSI && msiEnable
      |=> pendKind_reg[g] == leis_pkg::LEIS_MSI)
      else $error("enabled MSI not queued");

    a_msi_gated: assert property (
      rise[g] && actionCode[g] == `LEIS_CODE_MSI && !msiEnable
      && pendKind_reg[g] == leis_pkg::LEIS_NONE
      |=> pendKind_reg[g] == leis_pkg::LEIS_NONE)
      else $error("MSI queued while disabled");

    a_intx_assert: assert property (
      rise[g] && actionCode[g] >= `LEIS_CODE_INTA
      && actionCode[g] <= `LEIS_CODE_INTD && !intxDisable
      |=> pendKind_reg[g] == leis_pkg::LEIS_ASSERT
          && pendPin_reg[g] == $past(actionCode[g][1:0]) - 2'h2)
      else $error("INTx assert wrong or missing");

    a_intx_negate: assert property (
      fall[g] && actionCode[g] >= `LEIS_CODE_INTA
      && actionCode[g] <= `LEIS_CODE_INTD && !intxDisable
      |=> pendKind_reg[g] == leis_pkg::LEIS_NEGATE)
      else $error("INTx negate missing on clear");

    a_msi_no_fall: assert property (
      fall[g] && actionCode[g] == `LEIS_CODE_MSI
      && pendKind_reg[g] == leis_pkg::LEIS_NONE
      |=> pendKind_reg[g] == leis_pkg::LEIS_NONE)
      else $error("MSI queued on a cleared bit");

    a_intx_gated: assert property (
      (rise[g] || fall[g]) && intxDisable
      && actionCode[g] >= `LEIS_CODE_INTA
      && pendKind_reg[g] == leis_pkg::LEIS_NONE
      |=> pendKind_reg[g] == leis_pkg::LEIS_NONE)
      else $error("INTx queued while disabled");
  end

  c_msi_sent: cover property (
    msgValid && msgReady && msgKind == leis_pkg::LEIS_MSI);
  c_intx_pair: cover property (
    msgValid && msgKind == leis_pkg::LEIS_ASSERT
    ##[1:50] msgValid && msgKind == leis_pkg::LEIS_NEGATE);
  c_stall: cover property (msgValid && !msgReady ##1 msgValid && msgReady);
  c_irq: cover property (irq);

endmodule

// *** leis_host_model.sv ***
// upstream message sink standing in for the host side of the selector
`timescale 1ns/1ps
`include "leis_regs.svh"

module leis_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // stall pattern select
  input wire logic slow,
  // message handshake
  input wire logic msgValid,
  output logic msgReady,
  input wire leis_pkg::leis_kind_t msgKind,
  input wire logic [1:0] msgPin,
  input wire logic [`LEIS_IDX_W-1:0] msgEvent
);
  logic [1:0] stallCnt = 2'h0;
  logic [6:0] log[$];

  // slow mode takes one cycle in four, so offers must stand while refused
  assign msgReady = !slow || (stallCnt == 2'h3);

  always @(posedge clk) begin
    stallCnt <= srst ? 2'h0 : stallCnt + 2'h1;
    if (!srst && msgValid && msgReady) begin
      log.push_back({msgKind, msgPin, msgEvent});
    end
  end
endmodule

// *** leis_top_tb.sv ***
// self-checking bench of the link event action selector
`timescale 1ns/1ps
`include "leis_regs.svh"

module leis_top_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [31:0] regRdData;
  logic [5:0] eventFlags = 6'h00;
  logic msiEnable = 1'b1;
  logic intxDisable = 1'b0;
  logic slow = 1'b0;
  logic msgValid;
  logic msgReady;
  leis_pkg::leis_kind_t msgKind;
  logic [1:0] msgPin;
  logic [2:0] msgEvent;
  logic irq;
  logic [31:0] d;
  int num_errors = 0;
  int n_compared = 0;

  always #10 clk = ~clk;

  leis_top u_dut (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .eventFlags(eventFlags), .msiEnable(msiEnable),
    .intxDisable(intxDisable), .msgValid(msgValid), .msgReady(msgReady),
    .msgKind(msgKind), .msgPin(msgPin), .msgEvent(msgEvent), .irq(irq));

  leis_host_model u_host (.clk(clk), .srst(srst), .slow(slow),
    .msgValid(msgValid), .msgReady(msgReady), .msgKind(msgKind),
    .msgPin(msgPin), .msgEvent(msgEvent));

  task automatic chkReg(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkMsg(string what, logic [6:0] exp, logic [6:0] got);
    chkReg(what, {25'h0, exp}, {25'h0, got});
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 v = regRdData;
  endtask

  task automatic setFlag(int e, logic v);
    @(posedge clk);
    eventFlags[e] <= v;
  endtask

  // pin carries no meaning for an MSI, so it is not judged there
  task automatic expMsg(logic [1:0] k, logic [1:0] p, int e);
    int n;
    logic [6:0] got;
    n = u_host.log.size();
    for (int i = 0; i < 40 && u_host.log.size() == n; i++) @(posedge clk);
    chkReg("message count", n + 1, u_host.log.size());
    got = u_host.log[$];
    if (k == leis_pkg::LEIS_MSI) got[4:3] = p;
    chkMsg("message", {k, p, 3'(e)}, got);
  endtask

  task automatic expNone();
    int n;
    n = u_host.log.size();
    repeat (12) @(posedge clk);
    chkReg("silent count", n, u_host.log.size());
  endtask

  task automatic t_reset();
    rd(`LEIS_CTRL_OFS, d);
    chkReg("control reset", 32'h0, d);
    rd(12'h300, d);
    chkReg("unmapped read", 32'h0, d);
    chkReg("irq reset", 32'h0, {31'h0, irq});
  endtask

  task automatic t_fields();
    wr(`LEIS_CTRL_OFS, 32'hFFFFFFFF);
    rd(`LEIS_CTRL_OFS, d);
    chkReg("control upper", 32'h0003FFFF, d);
    for (int i = 0; i < 6; i++) begin
      wr(`LEIS_CTRL_OFS, 32'h5 << (3 * i));
      rd(`LEIS_CTRL_OFS, d);
      chkReg("field place", 32'h5 << (3 * i), d);
    end
  endtask

  task automatic t_codes();
    int e;
    // codes 6 and 7 break the software contract on purpose to reach the fallback
    for (int c = 0; c < 8; c++) begin
      e = c % 6;
      wr(`LEIS_CTRL_OFS, 32'(c) << (3 * e));
      setFlag(e, 1'b1);
      if (c == 1) expMsg(leis_pkg::LEIS_MSI, 2'h0, e);
      else if (c >= 2 && c <= 5) expMsg(leis_pkg::LEIS_ASSERT, 2'(c - 2), e);
      else expNone();
      setFlag(e, 1'b0);
      if (c >= 2 && c <= 5) expMsg(leis_pkg::LEIS_NEGATE, 2'(c - 2), e);
      else expNone();
    end
  endtask

  task automatic t_gate();
    wr(`LEIS_IRQ_STAT_OFS, 32'hF);
    wr(`LEIS_CTRL_OFS, 32'h1 << 6 | 32'h4 << 9);
    msiEnable <= 1'b0;
    intxDisable <= 1'b1;
    setFlag(2, 1'b1);
    expNone();
    setFlag(3, 1'b1);
    expNone();
    setFlag(3, 1'b0);
    expNone();
    setFlag(2, 1'b0);
    msiEnable <= 1'b1;
    intxDisable <= 1'b0;
    expNone();
    rd(`LEIS_IRQ_STAT_OFS, d);
    chkReg("status suppress", 32'h4, d);
  endtask

  task automatic t_irq();
    wr(`LEIS_IRQ_STAT_OFS, 32'hF);
    wr(`LEIS_IRQ_MASK_OFS, 32'h0);
    wr(`LEIS_CTRL_OFS, 32'h1);
    setFlag(0, 1'b1);
    expMsg(leis_pkg::LEIS_MSI, 2'h0, 0);
    rd(`LEIS_IRQ_STAT_OFS, d);
    chkReg("status msi", 32'h1, d);
    chkReg("irq masked", 32'h0, {31'h0, irq});
    wr(`LEIS_IRQ_MASK_OFS, 32'h1);
    #1 chkReg("irq raised", 32'h1, {31'h0, irq});
    wr(`LEIS_IRQ_STAT_OFS, 32'h1);
    #1 chkReg("irq cleared", 32'h0, {31'h0, irq});
    rd(`LEIS_IRQ_STAT_OFS, d);
    chkReg("status clear", 32'h0, d);
    setFlag(0, 1'b0);
    expNone();
  endtask

  // both events at once under a stalling host: lowest index goes first
  task automatic t_slow();
    int n;
    logic [1:0] k;
    wr(`LEIS_IRQ_STAT_OFS, 32'hF);
    wr(`LEIS_CTRL_OFS, 32'h2 | 32'h5 << 3);
    slow <= 1'b1;
    for (int ph = 0; ph < 2; ph++) begin
      k = ph ? leis_pkg::LEIS_NEGATE : leis_pkg::LEIS_ASSERT;
      n = u_host.log.size();
      @(posedge clk);
      eventFlags[1:0] <= ph ? 2'b00 : 2'b11;
      for (int i = 0; i < 80 && u_host.log.size() < n + 2; i++) @(posedge clk);
      chkReg("pair count", n + 2, u_host.log.size());
      chkMsg("first of pair", {k, 2'h0, 3'h0}, u_host.log[n]);
      chkMsg("second of pair", {k, 2'h3, 3'h1}, u_host.log[n + 1]);
    end
    slow <= 1'b0;
    rd(`LEIS_IRQ_STAT_OFS, d);
    chkReg("status intx", 32'h2, d);
  endtask

  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_fields();
    t_codes();
    t_gate();
    t_irq();
    t_slow();
    summarize();
  end

  // the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
